//--- hdl/icr_pkg.sv
/*
 package for the input control / memory port select block: register
 indices and byte addresses, field positions, reset values, counts.
 assumes a 32-bit apb slave with byte address = index * 4.
*/
// Summary of operation
// [R1] interrupt pin is active low when polarity bit is 0, high when 1
// [R2] de-bounce bit set filters external interrupt pin over 1,024 oscillator cycles
// [R3] trigger field: 00 low level, 01 falling, 10 high level, 11 rising edge
// [R4] text mode bit 1 selects text; reads 0 while canvas is linear
// [R5] host checks core busy status before flipping text/graphic mode
// [R6] destination 00 sends memory port traffic to display ram, read-modify-write allowed
// [R7] destination 01 writes gamma tables, 256 bytes each, written continuously
// [R8] destination 10 writes cursor ram with low eight data bits; no reads
// [R9] cursor ram holds four sets of 128x16 bits, 256 bytes each
// [R10] destination 11 writes 64x12 palette; even bytes keep only low nibble
// [R11] palette cannot be read; host writes all 128 bytes continuously
// [R12] writing gamma set selection clears the gamma address counter
// [R13] first read after switching port destination returns a dummy value
// [R14] debounced level changes only after staying stable the full period
// [R15] gamma, cursor and palette each keep a counter stepping per byte
package input_control_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [9:0] INPUT_CONTROL_IDX = 10'h003;
    localparam logic [9:0] MDP_IDX = 10'h004;
    localparam logic [9:0] STAT_IDX = 10'h008;
    localparam logic [9:0] MASK_IDX = 10'h009;
    localparam logic [9:0] SEL_IDX = 10'h00a;
    localparam logic [11:0] INPUT_CONTROL_ADDR = {INPUT_CONTROL_IDX, 2'b00};
    localparam logic [11:0] MDP_ADDR = {MDP_IDX, 2'b00};
    localparam logic [11:0] STAT_ADDR = {STAT_IDX, 2'b00};
    localparam logic [11:0] MASK_ADDR = {MASK_IDX, 2'b00};
    localparam logic [11:0] SEL_ADDR = {SEL_IDX, 2'b00};
    localparam logic [7:0] INPUT_CONTROL_RST = 8'h00;
    localparam logic [7:0] INPUT_CONTROL_WMASK = 8'hf7;
    localparam int POL_BIT = 7;
    localparam int DEB_BIT = 6;
    localparam int TRIG_LSB = 4;
    localparam int TEXT_BIT = 2;
    localparam int DEST_LSB = 0;
    localparam int GSEL_LSB = 0;
    localparam int CSEL_LSB = 2;
    typedef enum logic [1:0] {
        DEST_DISP = 2'b00, DEST_GAMMA = 2'b01, DEST_CURSOR = 2'b10, DEST_PAL = 2'b11
    } dest_e;
    typedef enum logic [1:0] {
        TRIG_LOW = 2'b00, TRIG_FALL = 2'b01, TRIG_HIGH = 2'b10, TRIG_RISE = 2'b11
    } trig_e;
    localparam int NUM_EV = 3;
    localparam int EV_EXT = 0;
    localparam int EV_DONE = 1;
    localparam int EV_REFUSED = 2;
    localparam logic [NUM_EV-1:0] STAT_RST = 3'h0;
    localparam logic [NUM_EV-1:0] MASK_RST = 3'h0;
    localparam int DEBOUNCE_CYCLES = 1024;
    localparam int TABLE_BYTES = 256;
    localparam int PAL_BYTES = 128;
    localparam int PAL_ENTRIES = 64;
    localparam int PAL_W = 12;
    localparam logic [7:0] TABLE_LAST = 8'(TABLE_BYTES - 1);
    localparam logic [6:0] PAL_LAST = 7'(PAL_BYTES - 1);
    localparam logic [7:0] DUMMY_DATA = 8'h00;
    localparam logic EXT_IDLE = 1'b1;
endpackage

//--- hdl/memport_if.sv
/*
 write carrier from the register block into one lookup table.
 assumes writer and table share clk_i.
*/
`timescale 1ns/10ps
interface memport_if #(parameter int AW = 10, parameter int DW = 8);
    logic wr;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
    modport src (output wr, output addr, output data);
    modport sink (input wr, input addr, input data);
endinterface

//--- hdl/table_ram.sv
/*
 one write port table with a registered lookup read port.
 assumes writes arrive on clk_i through memport_if.
*/
`timescale 1ns/10ps
module table_ram #(
    parameter int AW = 10,
    parameter int DW = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    memport_if.sink wp,
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge clk_i) begin
        if (wp.wr) begin
            mem[wp.addr] <= wp.data;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem[raddr_i];
        end
    end
endmodule // table_ram

//--- hdl/ext_debounce.sv
/*
 synchroniser and de-bounce filter for the external interrupt pin.
 assumes the oscillator clock is clk_i; the pin is asynchronous.
*/
`timescale 1ns/10ps
module ext_debounce
    import input_control_pkg::*;
#(
    parameter int CYCLES = input_control_pkg::DEBOUNCE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic raw_i,
    input wire logic en_i,
    output logic level_o
);
    import input_control_pkg::*;
    typedef struct packed {
        logic s1;
        logic s2;
        logic stable;
        logic [$clog2(CYCLES)-1:0] cnt;
    } deb_s;
    deb_s q, d;

    always_comb begin
        d = q;
        d.s1 = raw_i;
        d.s2 = q.s1;
        if (!en_i) begin
            d.stable = q.s2;
            d.cnt = '0;
        end else if (q.s2 == q.stable) begin
            d.cnt = '0; // R14
        end else if (q.cnt == ($clog2(CYCLES))'(CYCLES - 1)) begin
            d.stable = q.s2; // R2
            d.cnt = '0;
        end else begin
            d.cnt = q.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '{s1: EXT_IDLE, s2: EXT_IDLE, stable: EXT_IDLE, default: '0};
        end else begin
            q <= d;
        end
    end

    assign level_o = q.stable;

    deb_bypass_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R2
        !en_i && !$past(en_i) && !$past(en_i, 2) |-> level_o == $past(raw_i, 3))
        else $error("bypassed pin level wrong");
    deb_filter_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R14
        en_i && $past(en_i) && $changed(level_o) |-> $past(q.cnt) == ($clog2(CYCLES))'(CYCLES - 1))
        else $error("level accepted before full period");
endmodule // ext_debounce

//--- hdl/input_control_memport_select.sv
/*
 input control register bank with memory port destination routing.
 apb slave, one wait state per access; gamma, cursor and palette
 tables live here; display ram sits outside on a simple strobe port.
 assumes canvas_linear_i and disp_rdata_i come from logic on clk_i.
*/
// Our own choice: the APB slave port.
`timescale 1ns/10ps
module input_control_memport_select
    import input_control_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [input_control_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [input_control_pkg::DATA_W-1:0] pwdata_i,
    output logic [input_control_pkg::DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic ext_irq_input_pin_i,
    input wire logic canvas_linear_i,
    output logic irq_pin_o,
    output logic text_mode_o,
    output logic disp_wr_o,
    output logic disp_rd_o,
    output logic [7:0] disp_wdata_o,
    input wire logic [7:0] disp_rdata_i,
    input wire logic [9:0] gamma_raddr_i,
    output logic [7:0] gamma_rdata_o,
    input wire logic [9:0] cursor_raddr_i,
    output logic [7:0] cursor_rdata_o,
    input wire logic [5:0] pal_raddr_i,
    output logic [input_control_pkg::PAL_W-1:0] pal_rdata_o
);
    import input_control_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [7:0] input_control;
        logic [NUM_EV-1:0] stat;
        logic [NUM_EV-1:0] mask;
        logic [1:0] gsel;
        logic [1:0] csel;
        logic [7:0] gcnt;
        logic [7:0] ccnt;
        logic [6:0] pcnt;
        logic [3:0] pnib;
        logic dummy;
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
        logic irq_pin;
        logic text;
        logic disp_wr;
        logic disp_rd;
        logic [7:0] disp_wdata;
        logic ext_prev;
    } state_s;

    state_s q, d;
    logic ext_level;
    logic access;
    logic commit;
    logic wr_c;
    logic rd_c;
    logic hit;
    logic refuse;
    logic ext_event;
    logic [DATA_W-1:0] rd_val;
    logic [NUM_EV-1:0] ev;
    logic [NUM_EV-1:0] clr;
    logic [7:0] control_view;
    dest_e dest;
    trig_e trig;

    memport_if #(.AW(10), .DW(8)) gamma_port();
    memport_if #(.AW(10), .DW(8)) cursor_port();
    memport_if #(.AW(6), .DW(PAL_W)) pal_port();

    assign access = psel_i & penable_i;
    assign commit = access & q.pready;
    assign wr_c = commit & pwrite_i;
    assign rd_c = commit & ~pwrite_i;
    assign dest = dest_e'(q.input_control[DEST_LSB +: 2]);
    assign trig = trig_e'(q.input_control[TRIG_LSB +: 2]);
    assign control_view = {q.input_control[7:3], q.input_control[TEXT_BIT] & ~canvas_linear_i,
        q.input_control[1:0]}; // R4

    ////////////////////////////////////////////////////////////////////
    // external interrupt pin

    ext_debounce #(
        .CYCLES(DEBOUNCE_CYCLES)
    ) u_debounce (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .raw_i(ext_irq_input_pin_i),
        .en_i(q.input_control[DEB_BIT]), // R2
        .level_o(ext_level)
    );

    always_comb begin
        case (trig) // R3
            TRIG_LOW: ext_event = ~ext_level;
            TRIG_FALL: ext_event = q.ext_prev & ~ext_level;
            TRIG_HIGH: ext_event = ext_level;
            TRIG_RISE: ext_event = ~q.ext_prev & ext_level;
            default: ext_event = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // lookup tables

    // gamma: set in the top two address bits, byte index below
    assign gamma_port.wr = wr_c && paddr_i == MDP_ADDR && dest == DEST_GAMMA; // R7
    assign gamma_port.addr = {q.gsel, q.gcnt};
    assign gamma_port.data = pwdata_i[7:0];

    // cursor: four sets of 256 bytes, low data byte only
    assign cursor_port.wr = wr_c && paddr_i == MDP_ADDR && dest == DEST_CURSOR; // R8 R9
    assign cursor_port.addr = {q.csel, q.ccnt};
    assign cursor_port.data = pwdata_i[7:0];

    // palette: even byte gives a nibble, odd byte completes the entry
    assign pal_port.wr = wr_c && paddr_i == MDP_ADDR && dest == DEST_PAL && q.pcnt[0]; // R10
    assign pal_port.addr = q.pcnt[6:1];
    assign pal_port.data = {q.pnib, pwdata_i[7:0]};

    table_ram #(.AW(10), .DW(8)) u_gamma (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .wp(gamma_port.sink),
        .raddr_i(gamma_raddr_i),
        .rdata_o(gamma_rdata_o)
    );

    table_ram #(.AW(10), .DW(8)) u_cursor (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .wp(cursor_port.sink),
        .raddr_i(cursor_raddr_i),
        .rdata_o(cursor_rdata_o)
    );

    table_ram #(.AW(6), .DW(PAL_W)) u_palette (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .wp(pal_port.sink),
        .raddr_i(pal_raddr_i),
        .rdata_o(pal_rdata_o)
    );

    ////////////////////////////////////////////////////////////////////
    // read decode

    always_comb begin
        hit = 1'b1;
        refuse = 1'b0;
        rd_val = '0;
        if (paddr_i == INPUT_CONTROL_ADDR) begin
            rd_val = {24'h0, control_view};
        end else if (paddr_i == MDP_ADDR) begin
            if (dest == DEST_DISP) begin
                rd_val = {24'h0, q.dummy ? DUMMY_DATA : disp_rdata_i}; // R6 R13
            end else if (!pwrite_i) begin
                refuse = 1'b1; // R8 R11
            end
        end else if (paddr_i == STAT_ADDR) begin
            rd_val = {{(DATA_W-NUM_EV){1'b0}}, q.stat};
        end else if (paddr_i == MASK_ADDR) begin
            rd_val = {{(DATA_W-NUM_EV){1'b0}}, q.mask};
        end else if (paddr_i == SEL_ADDR) begin
            rd_val = {28'h0, q.csel, q.gsel};
        end else begin
            hit = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        d = q;
        ev = '0;
        ev[EV_EXT] = ext_event;
        clr = '0;
        d.ext_prev = ext_level;
        d.disp_wr = 1'b0;
        d.disp_rd = 1'b0;
        // first access cycle prepares the answer, second one commits
        d.pready = access & ~q.pready;
        if (access && !q.pready) begin
            d.prdata = pwrite_i ? '0 : rd_val;
            d.pslverr = ~hit | refuse;
        end
        if (commit && (!hit || refuse)) begin
            ev[EV_REFUSED] = 1'b1;
        end
        if (wr_c && paddr_i == INPUT_CONTROL_ADDR) begin
            d.input_control = pwdata_i[7:0] & INPUT_CONTROL_WMASK;
            if (d.input_control[DEST_LSB +: 2] != q.input_control[DEST_LSB +: 2]) begin
                d.dummy = 1'b1; // R13
                d.pcnt = '0;
            end
        end
        if (wr_c && paddr_i == SEL_ADDR) begin
            d.gsel = pwdata_i[GSEL_LSB +: 2];
            d.csel = pwdata_i[CSEL_LSB +: 2];
            d.gcnt = '0; // R12
            d.ccnt = '0;
        end
        if (wr_c && paddr_i == MASK_ADDR) begin
            d.mask = pwdata_i[NUM_EV-1:0];
        end
        if (wr_c && paddr_i == STAT_ADDR) begin
            clr = pwdata_i[NUM_EV-1:0];
        end
        if (wr_c && paddr_i == MDP_ADDR) begin
            case (dest)
                DEST_DISP: begin
                    d.disp_wr = 1'b1; // R6
                    d.disp_wdata = pwdata_i[7:0];
                end
                DEST_GAMMA: begin
                    d.gcnt = q.gcnt + 8'h01; // R15 R7
                    ev[EV_DONE] = q.gcnt == TABLE_LAST;
                end
                DEST_CURSOR: begin
                    d.ccnt = q.ccnt + 8'h01; // R15 R9
                    ev[EV_DONE] = q.ccnt == TABLE_LAST;
                end
                DEST_PAL: begin
                    d.pcnt = q.pcnt + 7'h01; // R15 R11
                    if (!q.pcnt[0]) begin
                        d.pnib = pwdata_i[3:0]; // R10
                    end
                    ev[EV_DONE] = q.pcnt == PAL_LAST;
                end
                default: d.disp_wr = 1'b0;
            endcase
        end
        if (rd_c && paddr_i == MDP_ADDR && dest == DEST_DISP) begin
            d.disp_rd = 1'b1;
            d.dummy = 1'b0; // R13
        end
        // a new event wins over a clear in the same cycle
        d.stat = (q.stat & ~clr) | ev;
        d.irq_pin = (|(d.stat & d.mask)) == d.input_control[POL_BIT]; // R1
        d.text = d.input_control[TEXT_BIT] & ~canvas_linear_i; // R4
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '{input_control: INPUT_CONTROL_RST, stat: STAT_RST, mask: MASK_RST, dummy: 1'b1,
                irq_pin: 1'b1, ext_prev: EXT_IDLE, default: '0};
        end else begin
            q <= d;
        end
    end

    assign prdata_o = q.prdata;
    assign pready_o = q.pready;
    assign pslverr_o = q.pslverr;
    assign irq_pin_o = q.irq_pin;
    assign text_mode_o = q.text;
    assign disp_wr_o = q.disp_wr;
    assign disp_rd_o = q.disp_rd;
    assign disp_wdata_o = q.disp_wdata;

    ////////////////////////////////////////////////////////////////////
    // checks

    sequence s_first_access;
        psel_i && penable_i && !pready_o;
    endsequence

    sequence s_sel_write;
        wr_c && paddr_i == SEL_ADDR;
    endsequence

    sequence s_gamma_write;
        wr_c && paddr_i == MDP_ADDR && dest == DEST_GAMMA;
    endsequence

    apb_answer_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_first_access |=> pready_o ##1 !pready_o)
        else $error("apb answer timing wrong");

    pin_polarity_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R1
        irq_pin_o == ((|(q.stat & q.mask)) == q.input_control[POL_BIT]))
        else $error("interrupt pin polarity wrong");

    level_trig_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
        trig == TRIG_LOW && !ext_level |=> q.stat[EV_EXT])
        else $error("low level not flagged");

    edge_trig_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
        trig == TRIG_RISE && $rose(ext_level) && $stable(trig) |=> q.stat[EV_EXT])
        else $error("rising edge not flagged");

    text_forced_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R4
        canvas_linear_i |=> !text_mode_o)
        else $error("text mode shown on linear canvas");

    gamma_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R12
        s_sel_write |=> q.gcnt == 8'h00)
        else $error("gamma counter not cleared");

    gamma_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R15
        s_gamma_write |=> q.gcnt == $past(q.gcnt) + 8'h01)
        else $error("gamma counter did not step");

    dummy_first_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R13
        rd_c && paddr_i == MDP_ADDR && dest == DEST_DISP && q.dummy |-> prdata_o == '0 ##1 !q.dummy)
        else $error("dummy read returned data");

    cursor_noread_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R8
        rd_c && paddr_i == MDP_ADDR && dest != DEST_DISP |-> pslverr_o ##1 q.stat[EV_REFUSED])
        else $error("table read not refused");

    pal_nibble_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R10
        wr_c && paddr_i == MDP_ADDR && dest == DEST_PAL && !q.pcnt[0]
        |=> q.pnib == $past(pwdata_i[3:0]) && q.pcnt[0])
        else $error("palette even byte mishandled");

    disp_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R6
        wr_c && paddr_i == MDP_ADDR && dest == DEST_DISP |=> disp_wr_o && disp_wdata_o == $past(pwdata_i[7:0]))
        else $error("display write not passed on");

    table_done_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R7
        s_gamma_write ##0 q.gcnt == TABLE_LAST |=> q.stat[EV_DONE])
        else $error("gamma load end not flagged");
endmodule // input_control_memport_select

//--- testbench/apb_host_model.sv
/*
 apb host model standing in for the microcontroller.
 assumes one clock; the bench calls xfer for one transfer at a time.
*/
`timescale 1ns/10ps
module apb_host_model (
    input wire logic clk_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [11:0] paddr_o,
    output logic [31:0] pwdata_o,
    input wire logic pready_i,
    output logic hang_o
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 12'h000;
        pwdata_o = 32'h0;
        hang_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_i !== 1'b1 && n < 32);
        if (pready_i !== 1'b1) begin
            hang_o <= 1'b1;
        end
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        // released lines carry no stale value
        paddr_o <= ~a;
        pwdata_o <= ~d;
    endtask
endmodule // apb_host_model

//--- testbench/input_control_memport_select_tb.sv
/*
 self-checking bench: queue of expected apb answers, table lookups.
 assumes the apb host model and the design's package.
*/
`timescale 1ns/10ps
module input_control_memport_select_tb;
    import input_control_pkg::*;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} exp_s;
    logic clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr, hang;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic ext_pin, canvas_linear, irq_pin, text_mode, disp_wr, disp_rd;
    logic [7:0] disp_wdata, disp_rdata, gamma_rdata, cursor_rdata;
    logic [9:0] gamma_raddr, cursor_raddr;
    logic [5:0] pal_raddr;
    logic [11:0] pal_rdata;
    logic [31:0] seed = 32'h3e67;
    logic [7:0] mem [256];
    exp_s q[$];
    exp_s cur;
    int n_mismatch = 0;
    int total_checks = 0;

    apb_host_model host (.clk_i(clk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata), .pready_i(pready), .hang_o(hang));
    input_control_memport_select dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .ext_irq_input_pin_i(ext_pin),
        .canvas_linear_i(canvas_linear), .irq_pin_o(irq_pin), .text_mode_o(text_mode),
        .disp_wr_o(disp_wr), .disp_rd_o(disp_rd), .disp_wdata_o(disp_wdata), .disp_rdata_i(disp_rdata),
        .gamma_raddr_i(gamma_raddr), .gamma_rdata_o(gamma_rdata), .cursor_raddr_i(cursor_raddr),
        .cursor_rdata_o(cursor_rdata), .pal_raddr_i(pal_raddr), .pal_rdata_o(pal_rdata));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e = 1'b0);
        q.push_back('{32'h0, 32'h0, e});
        host.xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m = 32'hff,
                      input logic e = 1'b0);
        q.push_back('{x, m, e});
        host.xfer(1'b0, a, 32'h0);
    endtask
    task automatic pin(input logic l, input int n);
        @(posedge clk_i);
        ext_pin <= l;
        repeat (n) @(posedge clk_i);
    endtask
    task automatic irq_is(input logic l);
        repeat (3) @(posedge clk_i);
        chk(irq_pin, l);
    endtask
    task automatic look(input int k, input logic [9:0] a, input logic [11:0] x);
        @(posedge clk_i);
        gamma_raddr <= a;
        cursor_raddr <= a;
        pal_raddr <= a[5:0];
        repeat (2) @(posedge clk_i);
        #1;
        chk(k == 0 ? gamma_rdata : (k == 1 ? cursor_rdata : pal_rdata), x);
    endtask
    // k: 0 gamma, 1 cursor, 2 palette
    task automatic fill(input int k);
        int n;
        n = (k == 2) ? 128 : 256;
        wr(INPUT_CONTROL_ADDR, k + 1);
        for (int i = 0; i < 3 && k < 2; i++) begin
            wr(MDP_ADDR, rnd());
        end
        wr(SEL_ADDR, 32'h9);
        wr(STAT_ADDR, 32'h7);
        for (int i = 0; i < n; i++) begin
            v = rnd();
            mem[i] = v[7:0];
            wr(MDP_ADDR, v);
        end
        rd(STAT_ADDR, 32'h2, 32'h2);
        rd(MDP_ADDR, 32'h0, 32'hffffffff, 1'b1);
        for (int i = 0; i < 256; i++) begin
            if (k < 2) begin
                look(k, {(k == 0) ? 2'd1 : 2'd2, i[7:0]}, {4'h0, mem[i]});
            end else if (i < 64) begin
                look(k, 10'(i), {mem[2*i][3:0], mem[2*i+1]});
            end
        end
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        if (psel && penable && pready === 1'b1 && q.size() > 0) begin
            cur = q.pop_front();
            chk(prdata & cur.m, cur.d);
            chk({31'h0, pslverr}, {31'h0, cur.e});
        end
    end
    always @(posedge hang) begin
        n_mismatch++;
        conclude();
    end
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        rst_n_i = 1'b0;
        ext_pin = 1'b1;
        canvas_linear = 1'b0;
        disp_rdata = 8'h00;
        gamma_raddr = 10'h000;
        cursor_raddr = 10'h000;
        pal_raddr = 6'h00;
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        disp_rdata <= 8'(rnd());
        rd(INPUT_CONTROL_ADDR, 32'h0);
        rd(STAT_ADDR, 32'h0, 32'h7);
        rd(MASK_ADDR, 32'h0, 32'h7);
        chk(irq_pin, 1'b1);
        v = (rnd() & 32'hff) | 32'h04;
        wr(INPUT_CONTROL_ADDR, v);
        rd(INPUT_CONTROL_ADDR, v & 32'hf7);
        chk(text_mode, 1'b1);
        @(posedge clk_i);
        canvas_linear <= 1'b1;
        rd(INPUT_CONTROL_ADDR, v & 32'hf3);
        chk(text_mode, 1'b0);
        @(posedge clk_i);
        canvas_linear <= 1'b0;
        wr(INPUT_CONTROL_ADDR, 32'h00);
        wr(12'hffc, 32'h1, 1'b1);
        rd(12'h100, 32'h0, 32'hffffffff, 1'b1);
        wr(MASK_ADDR, 32'h4);
        irq_is(1'b0);
        wr(INPUT_CONTROL_ADDR, 32'h80);
        irq_is(1'b1);
        wr(STAT_ADDR, 32'h4);
        irq_is(1'b0);
        for (int t = 0; t < 4; t++) begin
            wr(INPUT_CONTROL_ADDR, t << 4);
            pin(!t[1], 8);
            wr(STAT_ADDR, 32'h7);
            rd(STAT_ADDR, 32'h0, 32'h1);
            pin(t[1], 8);
            rd(STAT_ADDR, 32'h1, 32'h1);
        end
        wr(INPUT_CONTROL_ADDR, 32'h50);
        pin(1'b1, 8);
        wr(STAT_ADDR, 32'h7);
        pin(1'b0, 500);
        pin(1'b1, 1100);
        rd(STAT_ADDR, 32'h0, 32'h1);
        pin(1'b0, 1000);
        rd(STAT_ADDR, 32'h0, 32'h1);
        repeat (60) @(posedge clk_i);
        rd(STAT_ADDR, 32'h1, 32'h1);
        pin(1'b1, 1100);
        for (int k = 0; k < 3; k++) begin
            fill(k);
        end
        wr(INPUT_CONTROL_ADDR, 32'h00);
        v = rnd();
        wr(MDP_ADDR, v);
        #1;
        chk(disp_wr, 1'b1);
        chk(disp_wdata, v[7:0]);
        rd(MDP_ADDR, 32'h0);
        #1;
        chk(disp_rd, 1'b1);
        rd(MDP_ADDR, {24'h0, disp_rdata});
        repeat (4) @(posedge clk_i);
        conclude();
    end
endmodule // input_control_memport_select_tb
